// ===== jdl_pkg.sv
// Notes on behaviour
// - full bandwidth adds 25/14/7/4/2 clocks
// - decimate 4 and 8 latency tables
// - some decimate 1/2 ratios unsupported
// - decimate 16 restricted by output type
// - subclass field bits 7:5, resets 001
// - subclass 0 runs without sysref
// - receiver aligns lanes with arbitrary clocks
// - sysref realigns multiframe clock and dividers
// - multiframe clock marks every multiframe start
// - receiver buffers to equalise lane latency
// - total latency variation within one multiframe
// - receive buffer releases on multiframe boundary
// - five-bit offset delays multiframe clock
// - offset step depends on octets per frame
// - readable sysref setup/hold monitor register
// - bit 4 selects sysref transition
// - bit 3 selects device clock edge
// - bit 0 selects synchronisation method
// - sync mode resets 0, normal alignment
// - use subclass 0 without latency needs
// - sync mode 1 tags sample, no reset
// - ones select falling transition and edge
// - monitor hold 7:4, setup 3:0
package jdl_pkg;
    // ----------------------------------------
    // device register map
    // ----------------------------------------
    localparam int          REG_AW          = 12;
    localparam logic [11:0] REG_SYSREF_CTRL = 12'h120;
    localparam logic [11:0] REG_WINDOW_MON  = 12'h128;
    localparam logic [11:0] REG_SYNC_MODE   = 12'h1ff;
    localparam logic [11:0] REG_MF_OFFSET   = 12'h578;
    localparam logic [11:0] REG_SUBCLASS    = 12'h590;
    // field positions
    localparam int TRANS_SEL_BIT = 4;
    localparam int EDGE_SEL_BIT  = 3;
    localparam int SYNC_MODE_BIT = 0;
    localparam int SUBCLASS_LSB  = 5;
    localparam int OFFSET_MSB    = 4;
    localparam int HOLD_LSB      = 4;
    // reset values
    localparam logic [7:0] SYSREF_CTRL_RST = 8'h00;
    localparam logic [7:0] SYNC_MODE_RST   = 8'h00;
    localparam logic [7:0] MF_OFFSET_RST   = 8'h00;
    localparam logic [7:0] SUBCLASS_RST    = 8'h20;
    localparam logic [7:0] WINDOW_MON_RST  = 8'h00;
    localparam logic [2:0] SUBCLASS_0      = 3'h0;
    localparam logic [2:0] SUBCLASS_1      = 3'h1;
    localparam logic [3:0] MON_SAT         = 4'hf;
    // ----------------------------------------
    // application modes and latency tables
    // ----------------------------------------
    typedef enum logic [2:0] {
        JDL_FULL_BAND, JDL_DEC1, JDL_DEC2, JDL_DEC4, JDL_DEC8, JDL_DEC16
    } jdl_mode_e;
    localparam int         NUM_RATIOS = 5;   // index 0..4 = 0.5,1,2,4,8
    localparam logic [8:0] LAT_NA     = 9'h000;
    localparam logic [8:0] JDL_LAT [6][5] = '{
        '{9'd25,  9'd14,  9'd7,  9'd4,  9'd2},
        '{9'd25,  9'd14,  9'd7,  LAT_NA, LAT_NA},
        '{9'd46,  9'd27,  9'd14, 9'd7,  LAT_NA},
        '{9'd88,  9'd50,  9'd27, 9'd14, 9'd7},
        '{9'd172, 9'd96,  9'd50, 9'd27, 9'd14},
        '{9'd339, 9'd188, 9'd96, 9'd50, 9'd27}};
    localparam logic [4:0] JDL_DECIM [6] = '{5'd1, 5'd1, 5'd2, 5'd4, 5'd8, 5'd16};
    // decimate 16: bit per ratio index
    localparam logic [4:0] DEC16_CPLX_ONLY = 5'h16;
    localparam logic [4:0] DEC16_REAL_ONLY = 5'h09;
    // ----------------------------------------
    // controller register map (axi4-lite)
    // ----------------------------------------
    localparam logic [7:0] HC_ADDR     = 8'h00;
    localparam logic [7:0] HC_WDATA    = 8'h04;
    localparam logic [7:0] HC_RDCMD    = 8'h08;
    localparam logic [7:0] HC_RDATA    = 8'h0c;
    localparam logic [7:0] HC_SYSREF   = 8'h10;
    localparam logic [7:0] HC_LINKSTAT = 8'h14;
    localparam int         RDONE_BIT   = 8;
    localparam logic [3:0] SYSREF_MIN_CLKS = 4'h2;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== jdl_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface jdl_link_if (
    input wire logic clk
);
    logic        regSel;     // register access strobe
    logic        regWe;      // 1 write, 0 read
    logic [11:0] regAddr;    // register offset
    logic [7:0]  regWData;   // write data
    logic [7:0]  regRData;   // read data
    logic        regRValid;  // read answer pulse
    logic        sysref;     // system reference
    logic [15:0] txData;     // delayed sample
    logic        txValid;    // decimated sample strobe
    logic        txTag;      // timestamp control bit
    logic        lmfcStart;  // multiframe start
    modport device (
        input  clk, regSel, regWe, regAddr, regWData, sysref,
        output regRData, regRValid, txData, txValid, txTag, lmfcStart
    );
    modport host (
        input  clk, regRData, regRValid, txData, txValid, txTag, lmfcStart,
        output regSel, regWe, regAddr, regWData, sysref
    );
endinterface
`default_nettype wire

// ===== jdl_device_end.sv
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module jdl_device_end #(
    parameter int K_FRAMES = 32,   // frames per multiframe
    parameter int MEM_AW   = 9     // delay line address width
) (
    input  wire logic               clk,
    input  wire logic               rst,
    jdl_link_if.device              link,
    input  wire logic [15:0]        sampleIn,
    input  wire jdl_pkg::jdl_mode_e modeSel,
    input  wire logic [2:0]         ratioSel,
    input  wire logic               complexOut,
    input  wire logic [4:0]         octetsPerFrame,
    output logic                    unsupportedCfg,
    output logic [8:0]              latencyClks
);
    import jdl_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0]        ctl;        // sysref control
        logic [7:0]        mon;        // window monitor
        logic [7:0]        sync;       // sync mode select
        logic [7:0]        ofs;        // multiframe offset
        logic [7:0]        sub;        // subclass select
        logic [7:0]        rdData;     // read answer data
        logic              rdValid;    // read answer strobe
        logic              sysPrev;    // last sampled sysref
        logic [3:0]        stableCnt;  // cycles level stable
        logic [3:0]        holdCnt;    // cycles after event
        logic              holdRun;    // hold counting active
        logic [4:0]        divCnt;     // sample divider
        logic [7:0]        frameCnt;   // frame in multiframe
        logic [MEM_AW-1:0] wrPtr;      // delay line write
        logic [15:0]       txData;
        logic              txValid;
        logic              txTag;
        logic              lmfc;
        logic              unsup;
        logic [8:0]        lat;
    } jdl_dev_s;

    jdl_dev_s st_reg;                       // registered state
    jdl_dev_s st_next;                      // next state
    logic [16:0] mem [2**MEM_AW];           // tag plus sample
    logic        sysrefFall;                // falling edge capture
    logic        sysS;                      // selected capture
    logic        evt;                       // alignment event
    logic        tagNow;                    // sample gets timestamp
    logic [4:0]  offFrames;                 // offset in frames
    logic [4:0]  decim;                     // divider ratio
    logic [8:0]  latLook;                   // table lookup
    logic        unsupLook;                 // config not allowed
    logic [MEM_AW-1:0] rdIdx;               // delay line read
    logic [16:0] rdEntry;                   // read word

    // ----------------------------------------
    // configuration lookup
    // ----------------------------------------
    // latency and support check per mode and ratio
    always_comb
    begin
        latLook   = LAT_NA;
        unsupLook = 1'b1;
        decim     = JDL_DECIM[0];
        if (ratioSel < 3'(NUM_RATIOS) && int'(modeSel) < 6)
        begin
            latLook = JDL_LAT[modeSel][ratioSel];
            decim   = JDL_DECIM[modeSel];
            unsupLook = (latLook == LAT_NA);
            if (modeSel == JDL_DEC16)
            begin
                if (DEC16_CPLX_ONLY[ratioSel] && !complexOut)
                    unsupLook = 1'b1;
                if (DEC16_REAL_ONLY[ratioSel] && complexOut)
                    unsupLook = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // sysref capture
    // ----------------------------------------
    // falling device clock edge sample
    always_ff @(negedge clk)
    begin
        if (rst)
            sysrefFall <= 1'b0;
        else
            sysrefFall <= link.sysref;
    end

    // event detection and offset scaling
    always_comb
    begin
        sysS = st_reg.ctl[EDGE_SEL_BIT] ? sysrefFall : link.sysref;
        if (st_reg.ctl[TRANS_SEL_BIT])
            evt = st_reg.sysPrev & ~sysS;
        else
            evt = ~st_reg.sysPrev & sysS;
        tagNow = evt & st_reg.sync[SYNC_MODE_BIT];
        if (octetsPerFrame == 5'd1)
            offFrames = {2'h0, st_reg.ofs[OFFSET_MSB:2]};
        else if (octetsPerFrame == 5'd2)
            offFrames = {1'h0, st_reg.ofs[OFFSET_MSB:1]};
        else
            offFrames = st_reg.ofs[OFFSET_MSB:0];
        rdIdx   = st_reg.wrPtr - MEM_AW'(st_reg.lat) + MEM_AW'(1);
        rdEntry = mem[rdIdx];
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        st_next         = st_reg;
        st_next.rdValid = 1'b0;
        st_next.unsup   = unsupLook;
        st_next.lat     = latLook;
        st_next.sysPrev = sysS;
        st_next.wrPtr   = st_reg.wrPtr + MEM_AW'(1);
        // register port writes
        if (link.regSel && link.regWe)
        begin
            case (link.regAddr)
                REG_SYSREF_CTRL: st_next.ctl  = link.regWData;
                REG_SYNC_MODE:   st_next.sync = link.regWData;
                REG_MF_OFFSET:   st_next.ofs  = link.regWData;
                REG_SUBCLASS:    st_next.sub  = link.regWData;
                default:         st_next.ctl  = st_next.ctl;  // monitor read only
            endcase
        end
        // register port reads, answer next cycle
        if (link.regSel && !link.regWe)
        begin
            st_next.rdValid = 1'b1;
            case (link.regAddr)
                REG_SYSREF_CTRL: st_next.rdData = st_reg.ctl;
                REG_WINDOW_MON:  st_next.rdData = st_reg.mon;
                REG_SYNC_MODE:   st_next.rdData = st_reg.sync;
                REG_MF_OFFSET:   st_next.rdData = st_reg.ofs;
                REG_SUBCLASS:    st_next.rdData = st_reg.sub;
                default:         st_next.rdData = 8'h00;
            endcase
        end
        // setup: cycles level stable before change
        if (sysS != st_reg.sysPrev)
            st_next.stableCnt = 4'h0;
        else if (st_reg.stableCnt != MON_SAT)
            st_next.stableCnt = st_reg.stableCnt + 4'h1;
        if (evt)
        begin
            st_next.mon     = {4'h0, st_reg.stableCnt};
            st_next.holdCnt = 4'h0;
            st_next.holdRun = 1'b1;
        end
        else if (st_reg.holdRun)
        begin
            if (sysS == st_reg.sysPrev && st_reg.holdCnt != MON_SAT)
            begin
                st_next.holdCnt = st_reg.holdCnt + 4'h1;
                st_next.mon[7:HOLD_LSB] = st_reg.holdCnt + 4'h1;
            end
            else
                st_next.holdRun = 1'b0;
        end
        // sample divider and frame counter
        st_next.lmfc    = 1'b0;
        st_next.txValid = 1'b0;
        if (st_reg.divCnt >= decim - 5'd1)
        begin
            st_next.divCnt  = 5'h0;
            st_next.txValid = ~unsupLook;
            st_next.lmfc = (st_reg.frameCnt == {3'h0, offFrames}) & ~unsupLook;
            if (st_reg.frameCnt >= 8'(K_FRAMES - 1))
                st_next.frameCnt = 8'h0;
            else
                st_next.frameCnt = st_reg.frameCnt + 8'h1;
        end
        else
            st_next.divCnt = st_reg.divCnt + 5'd1;
        if (evt && !st_reg.sync[SYNC_MODE_BIT]
            && st_reg.sub[7:SUBCLASS_LSB] == SUBCLASS_1)
        begin
            st_next.divCnt   = 5'h0;
            st_next.frameCnt = 8'h0;
        end
        // delayed sample out
        st_next.txData = rdEntry[15:0];
        st_next.txTag  = rdEntry[16] & ~unsupLook;
        if (rst)
        begin
            st_next           = '0;
            st_next.sub       = SUBCLASS_RST;
            st_next.ctl       = SYSREF_CTRL_RST;
            st_next.sync      = SYNC_MODE_RST;
            st_next.ofs       = MF_OFFSET_RST;
            st_next.mon       = WINDOW_MON_RST;
            st_next.unsup     = 1'b1;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    // state register
    always_ff @(posedge clk)
    begin
        st_reg <= st_next;
    end

    // delay line, tag travels with sample
    always_ff @(posedge clk)
    begin
        mem[st_reg.wrPtr] <= {tagNow, sampleIn};
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign link.regRData   = st_reg.rdData;
    assign link.regRValid  = st_reg.rdValid;
    assign link.txData     = st_reg.txData;
    assign link.txValid    = st_reg.txValid;
    assign link.txTag      = st_reg.txTag;
    assign link.lmfcStart  = st_reg.lmfc;
    assign unsupportedCfg  = st_reg.unsup;
    assign latencyClks     = st_reg.lat;
endmodule // jdl_device_end
`default_nettype wire

// ===== jdl_host_end.sv
`timescale 1ns/1ns
`default_nettype none
module jdl_host_end (
    input  wire logic        clk,
    input  wire logic        rst,
    jdl_link_if.host         link,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [15:0]      rxData,
    output logic             rxValid,
    output logic             rxTag,
    output logic             rxLmfc
);
    import jdl_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic        awRdy, wRdy, awGot, wGot, bVal, arRdy, rVal;
        logic [7:0]  awA;          // held write address
        logic [31:0] wD;           // held write data
        logic [3:0]  wS;           // held strobes
        logic [1:0]  bR, rR;
        logic [31:0] rD;
        logic [11:0] devAddr;      // target device register
        logic        sel, we;
        logic [7:0]  devWData;
        logic [7:0]  devRData;     // last read answer
        logic        rdDone;       // sticky answer flag
        logic [3:0]  sysCnt;       // sysref pulse remaining
        logic        sysOut;
        logic [7:0]  tagCnt;       // timestamps seen
        logic [15:0] rxD;
        logic        rxV, rxT, rxL;
    } jdl_host_s;

    jdl_host_s st_reg;
    jdl_host_s st_next;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        st_next     = st_reg;
        st_next.sel = 1'b0;
        // capture write address and data separately
        if (awvalid && st_reg.awRdy)
        begin
            st_next.awGot = 1'b1;
            st_next.awA   = awaddr;
        end
        if (wvalid && st_reg.wRdy)
        begin
            st_next.wGot = 1'b1;
            st_next.wD   = wdata;
            st_next.wS   = wstrb;
        end
        // perform write once both held
        if (st_reg.awGot && st_reg.wGot && !st_reg.bVal)
        begin
            st_next.awGot = 1'b0;
            st_next.wGot  = 1'b0;
            st_next.bVal  = 1'b1;
            st_next.bR    = RESP_OKAY;
            case ({st_reg.awA[7:2], 2'h0})
                HC_ADDR:
                    if (st_reg.wS[0]) st_next.devAddr = st_reg.wD[11:0];
                HC_WDATA:
                begin
                    st_next.sel      = 1'b1;
                    st_next.we       = 1'b1;
                    st_next.devWData = st_reg.wD[7:0];
                end
                HC_RDCMD:
                begin
                    st_next.sel    = 1'b1;
                    st_next.we     = 1'b0;
                    st_next.rdDone = 1'b0;
                end
                HC_SYSREF:
                    if (st_reg.wD[0]) st_next.sysCnt = SYSREF_MIN_CLKS;
                HC_RDATA, HC_LINKSTAT:
                    st_next.bR = RESP_OKAY;
                default:
                    st_next.bR = RESP_SLVERR;
            endcase
        end
        else if (st_reg.bVal && bready)
            st_next.bVal = 1'b0;
        // read channel
        if (arvalid && st_reg.arRdy)
        begin
            st_next.rVal = 1'b1;
            st_next.rR   = RESP_OKAY;
            case ({araddr[7:2], 2'h0})
                HC_ADDR:     st_next.rD = {20'h0, st_reg.devAddr};
                HC_RDATA:    st_next.rD = {23'h0, st_reg.rdDone, st_reg.devRData};
                HC_SYSREF:   st_next.rD = {31'h0, st_reg.sysOut};
                HC_LINKSTAT: st_next.rD = {24'h0, st_reg.tagCnt};
                HC_WDATA, HC_RDCMD:
                    st_next.rD = 32'h0;
                default:
                begin
                    st_next.rD = 32'h0;
                    st_next.rR = RESP_SLVERR;
                end
            endcase
        end
        else if (st_reg.rVal && rready)
            st_next.rVal = 1'b0;
        // device read answer, set wins over clear
        if (link.regRValid)
        begin
            st_next.devRData = link.regRData;
            st_next.rdDone   = 1'b1;
        end
        // sysref pulse generator
        st_next.sysOut = (st_next.sysCnt != 4'h0);
        if (st_next.sysCnt != 4'h0)
            st_next.sysCnt = st_next.sysCnt - 4'h1;
        st_next.rxD = link.txData;
        st_next.rxV = link.txValid;
        st_next.rxT = link.txTag;
        st_next.rxL = link.lmfcStart;
        if (link.txValid && link.txTag)
            st_next.tagCnt = st_reg.tagCnt + 8'h1;
        // ready flags mirror next holding state
        st_next.awRdy = !st_next.awGot && !st_next.bVal;
        st_next.wRdy  = !st_next.wGot && !st_next.bVal;
        st_next.arRdy = !st_next.rVal;
        if (rst)
            st_next = '0;
    end

    // state register
    always_ff @(posedge clk)
    begin
        st_reg <= st_next;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign awready       = st_reg.awRdy;
    assign wready        = st_reg.wRdy;
    assign bvalid        = st_reg.bVal;
    assign bresp         = st_reg.bR;
    assign arready       = st_reg.arRdy;
    assign rvalid        = st_reg.rVal;
    assign rdata         = st_reg.rD;
    assign rresp         = st_reg.rR;
    assign link.regSel   = st_reg.sel;
    assign link.regWe    = st_reg.we;
    assign link.regAddr  = st_reg.devAddr;
    assign link.regWData = st_reg.devWData;
    assign link.sysref   = st_reg.sysOut;
    assign rxData        = st_reg.rxD;
    assign rxValid       = st_reg.rxV;
    assign rxTag         = st_reg.rxT;
    assign rxLmfc        = st_reg.rxL;
endmodule // jdl_host_end
`default_nettype wire

// ===== jdl_chk.sv
`timescale 1ns/1ns
`default_nettype none
module jdl_chk
    import jdl_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        regSel,
    input wire logic        regWe,
    input wire logic [11:0] regAddr,
    input wire logic [7:0]  regWData,
    input wire logic [7:0]  regRData,
    input wire logic        regRValid,
    input wire logic        sysref,
    input wire logic        txValid,
    input wire logic        lmfcStart
);
    logic [7:0] ctlReg;  // shadow of reference control
    logic [7:0] subReg;  // shadow of subclass
    wire logic  rdReq = regSel && !regWe;
    wire logic  wrReq = regSel && regWe;
    // shadows follow device writes
    always_ff @(posedge clk)
    begin
        if (wrReq && regAddr == REG_SYSREF_CTRL) ctlReg <= regWData;
        if (wrReq && regAddr == REG_SUBCLASS) subReg <= regWData;
        if (rst)
        begin
            ctlReg <= SYSREF_CTRL_RST;
            subReg <= SUBCLASS_RST;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_read_answer: assert property (rdReq |=> regRValid) else $error("no answer");
    a_answer_cause: assert property (regRValid |-> $past(rdReq)) else $error("stray");
    a_write_silent: assert property (wrReq |=> !regRValid) else $error("answered");
    a_ctl_readback:
        assert property (rdReq && regAddr == REG_SYSREF_CTRL |=> regRData == ctlReg)
        else $error("control readback");
    a_sub_readback:
        assert property (rdReq && regAddr == REG_SUBCLASS |=> regRData == subReg)
        else $error("subclass readback");
    a_start_valid: assert property (lmfcStart |-> txValid) else $error("start off");
    a_start_single: assert property (lmfcStart |=> !lmfcStart) else $error("start");
    a_ref_pulse:
        assert property ($rose(sysref) |=> sysref ##1 !sysref) else $error("ref width");
    c_start: cover property (lmfcStart);
    c_answer: cover property (regRValid);
    c_ref: cover property ($rose(sysref));
endmodule // jdl_chk
`default_nettype wire

// ===== jesd_deterministic_latency_sync_tb.sv
`timescale 1ns/1ns
`default_nettype none
module jesd_deterministic_latency_sync_tb;
    import jdl_pkg::*;
    localparam int LT [30] = '{25, 14, 7, 4, 2, 25, 14, 7, 0, 0, 46, 27, 14, 7, 0,
        88, 50, 27, 14, 7, 172, 96, 50, 27, 14, 339, 188, 96, 50, 27};
    logic        clk = 0, rst = 1, cplx = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid, unsup;
    logic [15:0] sampleIn = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [1:0]  bresp, rresp, resp;
    logic [2:0]  ratio = 0;
    logic [4:0]  octets = 5'h04;
    logic [8:0]  latClks;
    jdl_mode_e   mode = JDL_FULL_BAND;
    int          errCount = 0, checkCount = 0, cyc = 0;
    jdl_link_if link (.clk(clk));
    jdl_device_end #(.K_FRAMES(4)) jdl_device_end_i (.clk(clk), .rst(rst), .link(link),
        .sampleIn(sampleIn), .modeSel(mode), .ratioSel(ratio), .complexOut(cplx),
        .octetsPerFrame(octets), .unsupportedCfg(unsup), .latencyClks(latClks));
    jdl_host_end jdl_host_end_i (.clk(clk), .rst(rst), .link(link), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .rxData(), .rxValid(), .rxTag(), .rxLmfc());
    jdl_chk jdl_chk_i (.clk(clk), .rst(rst), .regSel(link.regSel), .regWe(link.regWe),
        .regAddr(link.regAddr), .regWData(link.regWData), .regRData(link.regRData),
        .regRValid(link.regRValid), .sysref(link.sysref), .txValid(link.txValid),
        .lmfcStart(link.lmfcStart));
    always #4 clk = ~clk;
    // sample ramp and hang guard
    always @(posedge clk)
    begin
        sampleIn <= sampleIn + 16'h1;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errCount++;
            finishTest();
        end
    end
    task automatic finishTest();
        $display("checks %0d mismatches %0d", checkCount, errCount);
        if (errCount == 0 && checkCount > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin errCount++; $display("BAD %0t got %0h want %0h", $time, got, exp); end
    endtask
    // bus write: both channels offered, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {awaddr, wdata} <= {a, d};
        {awvalid, wvalid, bready} <= 3'h7;
        do
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end
        while (!rvalid);
        {d, resp} = {rdata, rresp};
        rready <= 1'b0;
    endtask
    // device register write unless data is expected plus one, read back, compare
    task automatic wrd(input logic [11:0] a, input logic [7:0] d, input logic [7:0] e);
        logic [31:0] w;
        w = 32'h0;
        if (d !== e + 8'h1) wr(HC_ADDR, {20'h0, a});
        if (d !== e + 8'h1) wr(HC_WDATA, {24'h0, d});
        wr(HC_RDCMD, 32'h0);
        for (int i = 0; i < 20 && w[8] !== 1'b1; i++) rd(HC_RDATA, w);
        chk(w, {23'h1, e});
    endtask
    task automatic tRegs();
        logic [31:0] w;
        wr(HC_ADDR, {20'h0, REG_SUBCLASS});
        wrd(REG_SUBCLASS, 8'h21, 8'h20);
        wr(HC_ADDR, {20'h0, REG_SYNC_MODE});
        wrd(REG_SYNC_MODE, 8'h01, 8'h00);
        wrd(REG_SYSREF_CTRL, 8'h18, 8'h18);
        wrd(REG_MF_OFFSET, 8'h1f, 8'h1f);
        wrd(REG_SUBCLASS, 8'h00, 8'h00);
        wrd(REG_WINDOW_MON, 8'h5a, 8'h00);
        wrd(REG_SUBCLASS, 8'h20, 8'h20);
        wrd(REG_SYSREF_CTRL, 8'h00, 8'h00);
        rd(8'h40, w);
        chk(w, 32'h0);
        chk(32'(resp), 32'(RESP_SLVERR));
        $display("registers done");
    endtask
    task automatic tLat();
        for (int k = 0; k < 60; k++)
        begin
            mode <= jdl_mode_e'(k / 10);
            {ratio, cplx} <= {3'((k / 2) % 5), 1'(k % 2)};
            repeat (3) @(posedge clk);
            chk(latClks, LT[k / 2]);
            chk(unsup, LT[k / 2] == 0 || (k / 10 == 5 && k % 2 == (k % 10 < 2 || k % 10 / 2 == 3)));
        end
        $display("latency table done");
    endtask
    task automatic tData();
        for (int r = 0; r < 5; r += 4)
        begin
            mode <= JDL_FULL_BAND;
            ratio <= 3'(r);
            repeat (60) @(posedge clk);
            #1;
            chk(link.txData, 16'(sampleIn - LT[r]));
        end
        $display("data delay done");
    endtask
    // cycles from six after reference to next multiframe start, and its period
    task automatic lmfcAt(input logic [7:0] o, output int d, output int p);
        wr(HC_ADDR, {20'h0, REG_MF_OFFSET});
        wr(HC_WDATA, {24'h0, o});
        wr(HC_SYSREF, 32'h1);
        repeat (6) @(posedge clk);
        for (d = 0; !link.lmfcStart; d++) @(posedge clk);
        for (p = 1; p == 1 || !link.lmfcStart; p++) @(posedge clk);
        p = p - 1;
    endtask
    task automatic tLmfc();
        int d0, d1, p;
        for (int f = 1; f <= 4; f *= 2)
        begin
            octets <= 5'(f);
            lmfcAt(8'h00, d0, p);
            lmfcAt(8'(4 / f), d1, p);
            chk((d1 - d0 + p) % p, p / 4);
        end
        $display("frame offset done");
    endtask
    task automatic tTag();
        logic seen;
        logic [31:0] w;
        seen = 1'b0;
        wr(HC_ADDR, {20'h0, REG_SYNC_MODE});
        wr(HC_WDATA, 32'h1);
        wr(HC_SYSREF, 32'h1);
        repeat (60) @(posedge clk) seen = seen | link.txTag;
        chk(seen, 1'b1);
        rd(HC_LINKSTAT, w);
        chk(w, 32'h1);
        wrd(REG_WINDOW_MON, 8'h00, {SYSREF_MIN_CLKS - 4'h1, MON_SAT});
        $display("tag done");
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        tRegs();
        tLat();
        tData();
        tLmfc();
        tTag();
        finishTest();
    end
endmodule // jesd_deterministic_latency_sync_tb
`default_nettype wire
